// [rtl/audio_rx_ctrl.sv]
`timescale 1ns/1ps
`include "audio_rx_ctrl_params.svh"
module audio_rx_ctrl
  import audio_rx_ctrl_pkg::*;
#(
  parameter logic [2:0] DIE_CODE = 3'h5  // arbitrary value
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // serial bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // interrupt pin, open drain
  input  wire logic       int_n_in,
  output logic            int_n_out,
  output logic            int_n_oe,
  // analog front-end status
  input  wire logic [3:0] upper_threshold_flag,
  input  wire logic [3:0] lower_threshold_flag,
  input  wire logic       audio_present_evt,
  input  wire logic       clip_evt,
  input  wire logic       jack_inserted,
  input  wire logic       overtemp,
  input  wire logic       zero_cross,
  // analog front-end control
  output logic [15:0]     diag_port_code,
  output logic            pullup_current_boost,
  output logic            mute,
  output logic            power_down,
  output logic [3:0]      left_gain_code,
  output logic [3:0]      right_gain_code
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] diag_comparator_status, next_diag_comparator_status;
  logic [3:0] event_flags, next_event_flags;
  logic       jack_seen, next_jack_seen;
  logic       temp_seen, next_temp_seen;
  logic [7:0] audio_control, next_audio_control;
  logic [7:0] bus_address_select, next_bus_address_select;
  logic [7:0] diag_port01_config, next_diag_port01_config;
  logic [7:0] diag_port23_config, next_diag_port23_config;
  logic [7:0] channel_gain, next_channel_gain;
  logic [1:0] target_sel, next_target_sel;
  logic       gain_pending, next_gain_pending;
  logic [7:0] gain_applied, next_gain_applied;
  logic       irq_low, next_irq_low;

  // serial engine
  bus_state_t state, next_state;
  wr_phase_t  phase, next_phase;
  logic       scl_d, sda_d;
  logic [2:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] index, next_index;
  logic       int_low_all, next_int_low_all;
  logic       next_sda_oe;
  // a fall right after start has no byte behind it; only count falls after a bit
  logic       got_bit, next_got_bit;
  logic       read_mode, next_read_mode;
  logic       addr_written, next_addr_written;

  logic       scl_rise, scl_fall, start_c, stop_c;
  logic [7:0] rd_data;
  logic       wr_strobe, rd_strobe;
  logic [7:0] wr_index;

  assign scl_rise = scl_in & ~scl_d;
  assign scl_fall = ~scl_in & scl_d;
  assign start_c  = scl_in & scl_d & sda_d & ~sda_in;
  assign stop_c   = scl_in & scl_d & ~sda_d & sda_in;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    case (index)
      `REG_DIAG_COMPARATOR_STATUS: rd_data = diag_comparator_status;
      `REG_EVENT_STATUS:           rd_data = {event_flags, 1'b0, DIE_CODE};
      `REG_AUDIO_CONTROL:          rd_data = audio_control;
      `REG_BUS_ADDRESS_SELECT:     rd_data = bus_address_select;
      `REG_DIAG_PORT01_CONFIG:     rd_data = diag_port01_config;
      `REG_DIAG_PORT23_CONFIG:     rd_data = diag_port23_config;
      `REG_CHANNEL_GAIN:           rd_data = channel_gain;
      default:                     rd_data = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // serial state machine
  // ---------------------------------------------------------------
  always_comb begin
    next_state       = state;
    next_phase       = phase;
    next_bitcnt      = bitcnt;
    next_shreg       = shreg;
    next_index       = index;
    next_int_low_all = int_low_all & ~int_n_in;
    next_sda_oe      = sda_oe;
    next_got_bit     = got_bit;
    wr_strobe        = 1'b0;
    rd_strobe        = 1'b0;
    wr_index         = index;
    if (start_c) begin
      next_state       = ST_ADDR;
      next_phase       = PH_ADDR;
      next_bitcnt      = 3'h0;
      next_sda_oe      = 1'b0;
      next_got_bit     = 1'b0;
      next_int_low_all = ~int_n_in;
    end else if (stop_c) begin
      next_state  = ST_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_sda_oe = 1'b0;
        end
        ST_ADDR, ST_WRX: begin
          if (scl_rise) begin
            next_shreg  = {shreg[6:0], sda_in};
            next_bitcnt = bitcnt + 3'h1;
            next_got_bit = 1'b1;
          end
          if (scl_fall && bitcnt == 3'h0 && got_bit) begin
            next_got_bit = 1'b0;
            if (state == ST_ADDR) begin
              if (shreg[7:1] == (`TARGET_ADDR_BASE | {5'h00, target_sel})) begin
                next_sda_oe = 1'b1;
                next_state  = ST_WACK;
                next_phase  = shreg[0] ? PH_DATA : PH_INDEX;
                if (shreg[0]) next_shreg = rd_data;
                if (shreg[0]) next_bitcnt = 3'h0;
              end else begin
                next_state = ST_IDLE;
              end
            end else begin
              next_sda_oe = 1'b1;
              next_state  = ST_WACK;
              if (phase == PH_INDEX) begin
                next_index = shreg;
                next_phase = PH_DATA;
              end else begin
                wr_strobe  = 1'b1;
                next_index = index + 8'h01;
              end
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            // ninth clock ends here; drop the acknowledge while clock is low
            next_bitcnt = 3'h0;
            next_sda_oe = 1'b0;
            next_state  = ST_WRX;
            if (read_mode) begin
              next_shreg  = rd_data;
              next_sda_oe = ~rd_data[7];
              next_state  = ST_RTX;
              rd_strobe   = 1'b1;
              next_index  = index + 8'h01;
            end
          end
        end
        ST_RTX: begin
          if (scl_fall) begin
            next_bitcnt = bitcnt + 3'h1;
            next_shreg  = {shreg[6:0], 1'b0};
            next_sda_oe = (bitcnt == 3'h7) ? 1'b0 : ~shreg[6];
            if (bitcnt == 3'h7) next_state = ST_RACK;
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_in) begin
              next_state = ST_IDLE;
            end else begin
              next_shreg = rd_data;
              rd_strobe  = 1'b1;
              next_index = index + 8'h01;
            end
          end
          if (scl_fall && state == ST_RACK) begin
            next_state  = ST_RTX;
            next_bitcnt = 3'h0;
            next_sda_oe = ~shreg[7];
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // direction bit is kept for the whole transfer after the address byte
  always_comb begin
    next_read_mode = read_mode;
    if (state == ST_ADDR && scl_fall && bitcnt == 3'h0 && got_bit) next_read_mode = shreg[0];
  end

  // ---------------------------------------------------------------
  // register file and event logic
  // ---------------------------------------------------------------
  logic [7:0] cmp_live;
  logic [7:0] sense_en;
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_port
      logic [3:0] code;
      assign code = p < 2 ? diag_port01_config[4*(p%2) +: 4] : diag_port23_config[4*(p%2) +: 4];
      // sensing is live for current codes and sense-only, not off or diode
      assign sense_en[2*p +: 2] = {2{code != `DIAG_CODE_OFF && code != `DIAG_CODE_DIODE}};
      assign cmp_live[2*p +: 2] = {upper_threshold_flag[p], lower_threshold_flag[p]};
    end
  endgenerate

  always_comb begin
    logic ev_audio, ev_clip, ev_jack, ev_temp, rd_clear;
    ev_audio = audio_present_evt & audio_control[`CTL_AUDIO_IRQ_BIT];
    ev_clip  = clip_evt & audio_control[`CTL_CLIP_IRQ_BIT];
    ev_jack  = (jack_inserted != jack_seen) & audio_control[`CTL_JACK_IRQ_BIT];
    ev_temp  = overtemp & ~temp_seen;
    rd_clear = rd_strobe && index == `REG_EVENT_STATUS;
    next_diag_comparator_status = (cmp_live & sense_en) | (diag_comparator_status & ~sense_en);
    next_jack_seen = jack_inserted;
    next_temp_seen = overtemp;
    next_event_flags = rd_clear ? 4'h0 : event_flags;
    next_irq_low     = rd_clear ? 1'b0 : irq_low;
    if (ev_audio) next_event_flags[3] = 1'b1;
    if (ev_clip)  next_event_flags[2] = 1'b1;
    if (ev_jack)  next_event_flags[1] = jack_inserted;
    if (ev_temp)  next_event_flags[0] = 1'b1;
    if (ev_audio | ev_clip | ev_jack | ev_temp) next_irq_low = 1'b1;
    next_audio_control      = audio_control;
    next_bus_address_select = bus_address_select;
    next_diag_port01_config = diag_port01_config;
    next_diag_port23_config = diag_port23_config;
    next_channel_gain       = channel_gain;
    next_target_sel         = target_sel;
    if (wr_strobe) begin
      case (wr_index)
        `REG_AUDIO_CONTROL:      next_audio_control = shreg & `CTL_WRITE_MASK;
        `REG_BUS_ADDRESS_SELECT: next_bus_address_select = shreg & `ADDR_SEL_MASK;
        `REG_DIAG_PORT01_CONFIG: next_diag_port01_config = shreg;
        `REG_DIAG_PORT23_CONFIG: next_diag_port23_config = shreg;
        `REG_CHANNEL_GAIN:       next_channel_gain = shreg;
        default:                 next_channel_gain = channel_gain;
      endcase
    end
    // address moves only at stop, after a write that saw the pin low throughout
    if (stop_c && addr_written && int_low_all) next_target_sel = bus_address_select[1:0];
    // enables clear on their own event; a same-cycle write loses
    if (ev_audio) next_audio_control[`CTL_AUDIO_IRQ_BIT] = 1'b0;
    if (ev_clip)  next_audio_control[`CTL_CLIP_IRQ_BIT]  = 1'b0;
    if (ev_jack)  next_audio_control[`CTL_JACK_IRQ_BIT]  = 1'b0;
    next_gain_pending = gain_pending;
    next_gain_applied = gain_applied;
    if (wr_strobe && wr_index == `REG_CHANNEL_GAIN) next_gain_pending = 1'b1;
    if (gain_pending && !(wr_strobe && wr_index == `REG_CHANNEL_GAIN) &&
        (!audio_control[`CTL_ZC_BIT] || zero_cross)) begin
      next_gain_applied = channel_gain;
      next_gain_pending = 1'b0;
    end
  end

  // the address write must be seen inside this transfer, cleared at each start
  always_comb begin
    next_addr_written = addr_written;
    if (start_c) next_addr_written = 1'b0;
    if (wr_strobe && wr_index == `REG_BUS_ADDRESS_SELECT) next_addr_written = 1'b1;
  end

  // ---------------------------------------------------------------
  // flip-flops
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state <= ST_IDLE; phase <= PH_ADDR; bitcnt <= 3'h0; shreg <= 8'h00;
      index <= 8'h00; int_low_all <= 1'b0; sda_oe <= 1'b0; read_mode <= 1'b0;
      scl_d <= 1'b1; sda_d <= 1'b1; addr_written <= 1'b0;
      got_bit <= 1'b0;
      diag_comparator_status <= `RST_REG; event_flags <= 4'h0;
      jack_seen <= 1'b0; temp_seen <= 1'b0; irq_low <= 1'b0;
      audio_control <= `RST_REG; bus_address_select <= `RST_REG;
      diag_port01_config <= `RST_REG; diag_port23_config <= `RST_REG;
      channel_gain <= `RST_REG; target_sel <= 2'h0;
      gain_pending <= 1'b0; gain_applied <= `RST_REG;
    end else begin
      state <= next_state; phase <= next_phase; bitcnt <= next_bitcnt; shreg <= next_shreg;
      index <= next_index; int_low_all <= next_int_low_all; sda_oe <= next_sda_oe;
      read_mode <= next_read_mode; scl_d <= scl_in; sda_d <= sda_in;
      addr_written <= next_addr_written;
      got_bit <= next_got_bit;
      diag_comparator_status <= next_diag_comparator_status; event_flags <= next_event_flags;
      jack_seen <= next_jack_seen; temp_seen <= next_temp_seen; irq_low <= next_irq_low;
      audio_control <= next_audio_control; bus_address_select <= next_bus_address_select;
      diag_port01_config <= next_diag_port01_config; diag_port23_config <= next_diag_port23_config;
      channel_gain <= next_channel_gain; target_sel <= next_target_sel;
      gain_pending <= next_gain_pending; gain_applied <= next_gain_applied;
    end
  end

  // open-drain pins only ever drive low
  assign sda_out              = 1'b0;
  assign int_n_out            = 1'b0;
  assign int_n_oe             = irq_low;
  assign diag_port_code       = {diag_port23_config, diag_port01_config};
  assign pullup_current_boost = audio_control[`CTL_BOOST_BIT];
  assign mute                 = audio_control[`CTL_MUTE_BIT];
  assign power_down           = audio_control[`CTL_PDOWN_BIT];
  assign left_gain_code       = gain_applied[7:4];
  assign right_gain_code      = gain_applied[3:0];

endmodule // audio_rx_ctrl

// [rtl/audio_rx_ctrl_params.svh]
`ifndef AUDIO_RX_CTRL_PARAMS_SVH
`define AUDIO_RX_CTRL_PARAMS_SVH

// ---------------------------------------------------------------
// register indices
// ---------------------------------------------------------------
`define REG_DIAG_COMPARATOR_STATUS 8'h00
`define REG_EVENT_STATUS           8'h01
`define REG_AUDIO_CONTROL          8'h02
`define REG_BUS_ADDRESS_SELECT     8'h03
`define REG_DIAG_PORT01_CONFIG     8'h04
`define REG_DIAG_PORT23_CONFIG     8'h05
`define REG_CHANNEL_GAIN           8'h06
`define REG_LAST                   8'h06

// ---------------------------------------------------------------
// reset values and fields
// ---------------------------------------------------------------
`define RST_REG               8'h00
`define TARGET_ADDR_BASE      7'h68
`define EV_AUDIO_BIT          7
`define EV_CLIP_BIT           6
`define EV_JACK_BIT           5
`define EV_TEMP_BIT           4
`define CTL_AUDIO_IRQ_BIT     7
`define CTL_CLIP_IRQ_BIT      6
`define CTL_JACK_IRQ_BIT      5
`define CTL_BOOST_BIT         3
`define CTL_ZC_BIT            2
`define CTL_MUTE_BIT          1
`define CTL_PDOWN_BIT         0
`define CTL_WRITE_MASK        8'hEF
`define ADDR_SEL_MASK         8'h03
`define DIAG_CODE_OFF         4'h0
`define DIAG_CODE_SENSE_ONLY  4'hE
`define DIAG_CODE_DIODE       4'hF

`endif

// [rtl/audio_rx_ctrl_pkg.sv]
package audio_rx_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_WACK  = 3'b010,
    ST_WRX   = 3'b011,
    ST_RTX   = 3'b100,
    ST_RACK  = 3'b101
  } bus_state_t;

  typedef enum logic [1:0] {
    PH_ADDR  = 2'b00,
    PH_INDEX = 2'b01,
    PH_DATA  = 2'b10
  } wr_phase_t;
endpackage

// [dv/audio_rx_ctrl_monitor.sv]
`timescale 1ns/1ps
module audio_rx_ctrl_monitor (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rstn,
  // bus and interrupt pins
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        int_n_out,
  input wire logic        int_n_oe,
  // front end
  input wire logic        audio_present_evt,
  input wire logic        clip_evt,
  input wire logic        jack_inserted,
  input wire logic        overtemp,
  input wire logic [15:0] diag_port_code,
  input wire logic        pullup_current_boost,
  input wire logic        mute,
  input wire logic        power_down
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic       sq;
  logic       dq;
  logic       jq;
  logic       in_frame;
  logic [3:0] since_ev;
  // ---------------------------------------------------------------
  // frame and event tracking
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    sq <= scl_in;
    dq <= sda_in;
    jq <= jack_inserted;
    if (!rstn) begin
      in_frame <= 1'b0;
      since_ev <= 4'hF;
    end else begin
      if (sq && scl_in && dq != sda_in) begin
        in_frame <= !sda_in;
      end
      if (audio_present_evt || clip_evt || overtemp || jack_inserted != jq) begin
        since_ev <= 4'h0;
      end else if (since_ev != 4'hF) begin
        since_ev <= since_ev + 4'h1;
      end
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_drive_after_fall;
    $rose(sda_oe) |-> !scl_in && $past(scl_in, 4);
  endproperty
  a_drive_after_fall: assert property (p_drive_after_fall) else $error("sda drive not after scl fall");
  property p_hold_while_high;
    scl_in && $past(scl_in) && $past(scl_in, 2) |-> $stable(sda_oe);
  endproperty
  a_hold_while_high: assert property (p_hold_while_high) else $error("sda drive moved in scl high");
  property p_open_drain;
    sda_out == 1'b0 && int_n_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain level not low");
  property p_int_cause;
    $rose(int_n_oe) |-> since_ev < 4'h4;
  endproperty
  a_int_cause: assert property (p_int_cause) else $error("interrupt without event");
  property p_overtemp_int;
    overtemp [*3] |=> int_n_oe;
  endproperty
  a_overtemp_int: assert property (p_overtemp_int) else $error("overtemp not flagged");
  property p_release_in_frame;
    $fell(int_n_oe) |-> in_frame || $past(in_frame) || $past(in_frame, 2);
  endproperty
  a_release_in_frame: assert property (p_release_in_frame) else $error("interrupt released off bus");
  property p_idle_quiet;
    !in_frame && !$past(in_frame) |-> !sda_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("sda driven outside frame");
  property p_ctrl_stable;
    !in_frame && !$past(in_frame) |-> $stable({diag_port_code, pullup_current_boost, mute, power_down});
  endproperty
  a_ctrl_stable: assert property (p_ctrl_stable) else $error("control changed outside frame");
  c_ack: cover property ($rose(sda_oe));
  c_int_set: cover property ($rose(int_n_oe));
  c_int_rel: cover property ($fell(int_n_oe));
  c_diag: cover property ($changed(diag_port_code));
endmodule // audio_rx_ctrl_monitor

bind audio_rx_ctrl audio_rx_ctrl_monitor audio_rx_ctrl_monitor_inst (
  .mclk(mclk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .int_n_out(int_n_out), .int_n_oe(int_n_oe), .audio_present_evt(audio_present_evt), .clip_evt(clip_evt),
  .jack_inserted(jack_inserted), .overtemp(overtemp), .diag_port_code(diag_port_code),
  .pullup_current_boost(pullup_current_boost), .mute(mute), .power_down(power_down));

// [dv/i2c_host_model.sv]
`timescale 1ns/1ps
module i2c_host_model #(
  parameter int Q = 5
) (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wait_q(input int n);
    repeat (n * Q) @(posedge mclk);
  endtask
  // also serves as repeated start from scl low
  task automatic start_cond();
    sda_low <= 1'b0;
    wait_q(1);
    scl <= 1'b1;
    wait_q(1);
    sda_low <= 1'b1;
    wait_q(1);
    scl <= 1'b0;
    wait_q(1);
  endtask
  task automatic stop_cond();
    sda_low <= 1'b1;
    wait_q(1);
    scl <= 1'b1;
    wait_q(1);
    sda_low <= 1'b0;
    wait_q(2);
  endtask
  task automatic put_bit(input logic b, output logic seen);
    sda_low <= !b;
    wait_q(1);
    scl <= 1'b1;
    wait_q(1);
    seen = sda;
    wait_q(1);
    scl <= 1'b0;
    wait_q(1);
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, ack);
  endtask
  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
    put_bit(nack, s);
  endtask
endmodule // i2c_host_model

// [dv/tb.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
  localparam logic [2:0] DIE = 3'h5;  // arbitrary value
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        scl;
  logic        m_low;
  logic        sda_oe;
  logic        int_oe;
  logic        tb_int_low = 1'b0;
  logic [3:0]  up = 4'hF;
  logic [3:0]  lo = 4'hF;
  logic [3:0]  evv = 4'h0;
  logic        zc = 1'b0;
  logic [15:0] dcode;
  logic        boost;
  logic        mute;
  logic        pdown;
  logic [3:0]  gl;
  logic [3:0]  gr;
  logic [7:0]  dev = 8'hD0;
  logic [7:0]  rq [$];
  logic [31:0] seed = 32'h4506;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  wire         sda = !(m_low || sda_oe);
  wire         int_w = !(int_oe || tb_int_low);
  initial forever #50 mclk = ~mclk;
  audio_rx_ctrl #(.DIE_CODE(DIE)) audio_rx_ctrl_inst (
    .mclk(mclk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .int_n_in(int_w), .int_n_out(), .int_n_oe(int_oe), .upper_threshold_flag(up), .lower_threshold_flag(lo),
    .audio_present_evt(evv[3]), .clip_evt(evv[2]), .jack_inserted(evv[1]), .overtemp(evv[0]),
    .zero_cross(zc), .diag_port_code(dcode), .pullup_current_boost(boost), .mute(mute),
    .power_down(pdown), .left_gain_code(gl), .right_gain_code(gr));
  i2c_host_model #(.Q(5)) i2c_host_model_inst (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(m_low));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  function automatic logic [3:0] nib();
    return 4'(rnd() % 8'd14) + 4'h1;
  endfunction
  // ports without sensing keep their last pair
  function automatic logic [7:0] stat_exp(logic [7:0] p, logic [15:0] c, logic [3:0] u, logic [3:0] l);
    for (int i = 0; i < 4; i++) begin
      if (c[4*i +: 4] inside {[4'h1:4'hE]}) begin
        p[2*i+1] = u[i];
        p[2*i] = l[i];
      end
    end
    return p;
  endfunction
  task automatic wr_regs(input logic [7:0] idx, input logic [7:0] d [$]);
    logic ack;
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.send_byte(dev, ack);
    `CHK("addr_ack", 1'b0, ack)
    i2c_host_model_inst.send_byte(idx, ack);
    foreach (d[i]) begin
      i2c_host_model_inst.send_byte(d[i], ack);
      `CHK("data_ack", 1'b0, ack)
    end
    i2c_host_model_inst.stop_cond();
  endtask
  task automatic rd_regs(input logic [7:0] idx, input int n);
    logic ack;
    logic [7:0] b;
    rq.delete();
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.send_byte(dev, ack);
    i2c_host_model_inst.send_byte(idx, ack);
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.send_byte(dev | 8'h01, ack);
    `CHK("rd_ack", 1'b0, ack)
    for (int i = 0; i < n; i++) begin
      i2c_host_model_inst.recv_byte(i == n - 1, b);
      rq.push_back(b);
    end
    i2c_host_model_inst.stop_cond();
  endtask
  task automatic probe(input logic [7:0] a, input logic nack);
    logic ack;
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.send_byte(a, ack);
    `CHK("probe_ack", nack, ack)
    i2c_host_model_inst.stop_cond();
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      end_of_test();
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] c;
    logic [7:0] d0;
    logic [7:0] g;
    logic [7:0] st;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    rd_regs(8'h00, 8);
    foreach (rq[i]) `CHK("reset_val", (i == 1) ? {5'h00, DIE} : 8'h00, rq[i])
    c = rnd() & 8'h0B;
    wr_regs(8'h02, '{c});
    `CHK("boost", c[3], boost)
    `CHK("mute_pd", c[1:0], {mute, pdown})
    d0 = {nib(), nib()};
    g = rnd();
    wr_regs(8'h04, '{d0, 8'h1E, g});
    `CHK("diag_code", {8'h1E, d0}, dcode)
    `CHK("gain", g, {gl, gr})
    rd_regs(8'h02, 5);
    `CHK("ctrl_rd", c, rq[0])
    `CHK("diag_rd", d0, rq[2])
    `CHK("gain_rd", g, rq[4])
    st = rnd();
    up <= st[3:0];
    lo <= st[7:4];
    repeat (4) @(posedge mclk);
    st = stat_exp(8'h00, {8'h1E, d0}, up, lo);
    rd_regs(8'h00, 1);
    `CHK("stat_on", st, rq[0])
    wr_regs(8'h05, '{8'hF0});
    up <= ~up;
    lo <= ~lo;
    repeat (4) @(posedge mclk);
    st = stat_exp(st, {8'hF0, d0}, up, lo);
    rd_regs(8'h00, 1);
    `CHK("stat_part", st, rq[0])
    wr_regs(8'h02, '{8'h04});
    wr_regs(8'h06, '{~g});
    `CHK("gain_hold", g, {gl, gr})
    zc <= 1'b1;
    @(posedge mclk);
    zc <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK("gain_zc", ~g, {gl, gr})
    wr_regs(8'h02, '{8'h00});
    evv <= 4'hC;
    repeat (3) @(posedge mclk);
    evv <= 4'h0;
    repeat (5) @(posedge mclk);
    `CHK("int_masked", 1'b1, int_w)
    for (int k = 0; k < 4; k++) begin
      wr_regs(8'h02, '{8'hE0});
      evv <= evv | (4'h8 >> k);
      repeat (5) @(posedge mclk);
      `CHK("int_set", 1'b0, int_w)
      evv <= evv & 4'h2;
      rd_regs(8'h01, 2);
      `CHK("event", (8'h80 >> k) | {5'h00, DIE}, rq[0])
      `CHK("irq_en", (k < 3) ? (8'hE0 & ~(8'h80 >> k)) : 8'hE0, rq[1])
      `CHK("int_rel", 1'b1, int_w)
    end
    tb_int_low <= 1'b1;
    wr_regs(8'h03, '{8'h02});
    tb_int_low <= 1'b0;
    probe(8'hD0, 1'b1);
    dev = 8'hD4;
    rd_regs(8'h03, 1);
    `CHK("addr_sel", 8'h02, rq[0])
    wr_regs(8'h03, '{8'h03});
    probe(8'hD6, 1'b1);
    probe(8'hD4, 1'b0);
    end_of_test();
  end
endmodule // tb
